/* rtl/rcpg_consts.vh */
/*
  Constants for the auxiliary rail control and power-good status bank.
  Assumes a 200 MHz system clock and a 32-bit classic Wishbone slave port.
*/
// Function
// - The aux rail control register sits at index AEh, all eight bits read/write, reset from factory OTP.
// - Bits 7:6 pick the regulator discharge load: none, 100, 200 or 500 ohm.
// - The shutdown-config and enable bits act on the regulator, the switch or nothing per device option.
// - With the regulator in sequence and switches not merged, the shutdown-config bit governs switch B2; the code keeps B2 off and skips regulator shutdown.
// - With bit 5 clear, an emergency shutdown turns the rail off for an OTP interval of 1, 5, 10 or 100 ms.
// - With bit 5 set, the rail follows the enable bit alone and ignores the shutdown interval.
// - Bits 4:1 hold the 4-bit voltage code, forwarded to the regulator setting.
// - Bit 0 enables the selected rail when 1 and disables it when 0.
// - Power-good status one sits at index B0h, read-only, reset zero: regulator two, switch A1, bucks 6..1.
// - Each power-good bit reads 1 while its rail is inside regulation, 0 otherwise.
// - Power-good status two sits at index B1h, read-only, reset zero, bits 7:6 reserved, 5..0 as listed.

`ifndef RCPG_CONSTS_VH
`define RCPG_CONSTS_VH

// Register indices; byte address is four times the index
`define RCPG_IDX_AUX_CTRL 8'hae
`define RCPG_IDX_PG_FIRST 8'hb0
`define RCPG_IDX_PG_SECOND 8'hb1
`define RCPG_IDX_EVT_STATUS 8'hc0
`define RCPG_IDX_EVT_MASK 8'hc1

// Control field positions
`define RCPG_DIS_HI 7
`define RCPG_DIS_LO 6
`define RCPG_SDCFG_BIT 5
`define RCPG_VID_HI 4
`define RCPG_VID_LO 1
`define RCPG_EN_BIT 0

// Device option codes
`define RCPG_OPT_UNUSED 2'h0
`define RCPG_OPT_REGULATOR 2'h1
`define RCPG_OPT_SWITCH 2'h2

// Event status bits
`define RCPG_EVT_SD_START 0
`define RCPG_EVT_SD_END 1
`define RCPG_EVT_PG1_LOST 2
`define RCPG_EVT_PG2_LOST 3
`define RCPG_EVT_BITS 4

// Widths and reset values
`define RCPG_PG2_BITS 6
`define RCPG_BYTE_ZERO 8'h00
`define RCPG_WORD_ZERO 32'h00000000

// Shutdown off intervals in clock cycles at 200 MHz: 1, 5, 10 and 100 ms
`define RCPG_SD_CNT_W 25
`define RCPG_SD_CYC0 25'd200000
`define RCPG_SD_CYC1 25'd1000000
`define RCPG_SD_CYC2 25'd2000000
`define RCPG_SD_CYC3 25'd20000000

`endif

/* rtl/rcpg_sync.v */
/*
  Three-stage input synchroniser with agreement filter.
  Assumes inputs are asynchronous to sys_clk.
*/
`timescale 1ns/1ps
module rcpg_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Data
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  integer i;

  // Stage one feeds only stage two
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  end

endmodule // rcpg_sync

/* rtl/rcpg_sd_timer.v */
/*
  Emergency shutdown off-interval timer.
  Assumes start is a one-cycle pulse and length is stable while busy.
*/
`timescale 1ns/1ps
`include "rcpg_consts.vh"
module rcpg_sd_timer #(
  parameter CNT_W = `RCPG_SD_CNT_W
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Control
  input wire start,
  input wire [CNT_W-1:0] length,
  output reg busy,
  output reg done
);

  reg [CNT_W-1:0] count;

  // Restart on a new shutdown extends the off time
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= {CNT_W{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= length;
        busy <= 1'b1;
      end else if (busy) begin
        if (count <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // rcpg_sd_timer

/* rtl/rcpg_regs.v */
/*
  Aux rail control and power-good status register bank, Wishbone classic slave.
  Assumes OTP straps are stable around reset release, power-good and shutdown
  inputs come from analog comparators asynchronous to sys_clk.
*/
`timescale 1ns/1ps
`include "rcpg_consts.vh"
module rcpg_regs #(
  parameter ADR_W = 10,
  parameter [`RCPG_SD_CNT_W-1:0] SD_CYC0 = `RCPG_SD_CYC0,
  parameter [`RCPG_SD_CNT_W-1:0] SD_CYC1 = `RCPG_SD_CYC1,
  parameter [`RCPG_SD_CNT_W-1:0] SD_CYC2 = `RCPG_SD_CYC2,
  parameter [`RCPG_SD_CNT_W-1:0] SD_CYC3 = `RCPG_SD_CYC3
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Factory OTP straps
  input wire [7:0] otp_ctrl_reset,
  input wire [1:0] otp_device_option,
  input wire [1:0] otp_sd_interval,
  input wire otp_in_sequence,
  input wire otp_switch_merged,
  // Analog status inputs
  input wire [7:0] pg_first_in,
  input wire [5:0] pg_second_in,
  input wire emergency_shutdown,
  // Rail controls
  output reg [1:0] aux_discharge_select,
  output reg [3:0] aux_voltage_code,
  output reg regulator_one_enable,
  output reg switch_b_two_enable,
  // Interrupt
  output reg irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg [7:0] aux_rail_control;
  reg otp_loaded;
  reg [1:0] dev_option;
  reg [1:0] sd_interval;
  reg sd_on_switch;
  reg [`RCPG_EVT_BITS-1:0] event_status;
  reg [`RCPG_EVT_BITS-1:0] event_mask;
  reg [7:0] pg_first_prev;
  reg [5:0] pg_second_prev;
  reg esd_prev;
  reg [`RCPG_SD_CNT_W-1:0] sd_length;
  reg [31:0] next_rdata;
  reg [`RCPG_EVT_BITS-1:0] next_event_status;

  wire [7:0] pg_first;
  wire [5:0] pg_second;
  wire esd_sync;
  wire sd_busy;
  wire sd_done;
  wire [7:0] reg_idx;
  wire bus_req;
  wire wr_go;
  wire wr_low;
  wire esd_rise;
  wire sd_start;
  wire sd_cfg;
  wire rail_en;
  wire off_reg;
  wire off_sw;
  wire wr_ctrl;
  wire wr_evt_clear;
  wire wr_evt_mask;
  wire rd_go;
  wire reg_target;
  wire sw_target;
  wire pg_first_fell;
  wire pg_second_fell;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  rcpg_sync #(
    .WIDTH(14)
  ) u_pg_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in({pg_second_in, pg_first_in}),
    .sync_out({pg_second, pg_first})
  );

  rcpg_sync #(
    .WIDTH(1)
  ) u_esd_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in(emergency_shutdown),
    .sync_out(esd_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  // Word aligned; only the index bits matter
  assign reg_idx = wb_adr_i[9:2];
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_go = bus_req & wb_we_i;
  assign wr_low = wr_go & wb_sel_i[0];
  assign rd_go = bus_req & ~wb_we_i;
  // One strobe per register; sel[0] gates every write
  // Control writes taken while the straps load are acked but lost
  assign wr_ctrl = wr_low & (reg_idx == `RCPG_IDX_AUX_CTRL);
  assign wr_evt_clear = wr_low & (reg_idx == `RCPG_IDX_EVT_STATUS);
  assign wr_evt_mask = wr_low & (reg_idx == `RCPG_IDX_EVT_MASK);

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // OTP capture and control register

  // Straps caught at the first edge after release, never by the reset itself
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      otp_loaded <= 1'b0;
      dev_option <= `RCPG_OPT_UNUSED;
      sd_interval <= 2'h0;
      sd_on_switch <= 1'b0;
      aux_rail_control <= `RCPG_BYTE_ZERO;
    end else if (!otp_loaded) begin
      otp_loaded <= 1'b1;
      dev_option <= otp_device_option;
      sd_interval <= otp_sd_interval;
      sd_on_switch <= (otp_device_option == `RCPG_OPT_SWITCH) |
                      (otp_in_sequence & ~otp_switch_merged);
      aux_rail_control <= otp_ctrl_reset;
    end else if (wr_ctrl) begin
      aux_rail_control <= wb_dat_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Emergency shutdown

  assign sd_cfg = aux_rail_control[`RCPG_SDCFG_BIT];
  assign rail_en = aux_rail_control[`RCPG_EN_BIT];
  assign esd_rise = esd_sync & ~esd_prev;
  // Config set: interval is skipped entirely
  assign sd_start = esd_rise & ~sd_cfg & otp_loaded;

  always @* begin
    case (sd_interval)
      2'h0: sd_length = SD_CYC0;
      2'h1: sd_length = SD_CYC1;
      2'h2: sd_length = SD_CYC2;
      2'h3: sd_length = SD_CYC3;
      default: sd_length = SD_CYC3;
    endcase
  end

  rcpg_sd_timer #(
    .CNT_W(`RCPG_SD_CNT_W)
  ) u_sd_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(sd_start),
    .length(sd_length),
    .busy(sd_busy),
    .done(sd_done)
  );

  // Off forcing only while config clear
  assign off_sw = sd_busy & ~sd_cfg & sd_on_switch;
  assign off_reg = sd_busy & ~sd_cfg & ~sd_on_switch;

  ////////////////////////////////////////////////////////////////////////////
  // Rail outputs

  // At most one target per device option; option codes 0 and 3 drive nothing
  assign reg_target = (dev_option == `RCPG_OPT_REGULATOR);
  assign sw_target = (dev_option == `RCPG_OPT_SWITCH);

  // Idle level of the shutdown pin is low, so no false edge after reset
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      esd_prev <= 1'b0;
    end else begin
      esd_prev <= esd_sync;
    end
  end

  // Field copies lag the register by one cycle
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      aux_discharge_select <= 2'h0;
      aux_voltage_code <= 4'h0;
    end else begin
      aux_discharge_select <= aux_rail_control[`RCPG_DIS_HI:`RCPG_DIS_LO];
      aux_voltage_code <= aux_rail_control[`RCPG_VID_HI:`RCPG_VID_LO];
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      regulator_one_enable <= 1'b0;
      switch_b_two_enable <= 1'b0;
    end else begin
      regulator_one_enable <= rail_en & ~off_reg & reg_target;
      switch_b_two_enable <= rail_en & ~off_sw & sw_target;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event status and interrupt

  // A falling good bit is the event; rising ones are not reported
  assign pg_first_fell = |(pg_first_prev & ~pg_first);
  assign pg_second_fell = |(pg_second_prev & ~pg_second);

  // Hardware set wins over a same-cycle write-one clear
  always @* begin
    next_event_status = event_status;
    if (wr_evt_clear) begin
      next_event_status = event_status & ~wb_dat_i[`RCPG_EVT_BITS-1:0];
    end
    if (sd_start) begin
      next_event_status[`RCPG_EVT_SD_START] = 1'b1;
    end
    if (sd_done) begin
      next_event_status[`RCPG_EVT_SD_END] = 1'b1;
    end
    if (pg_first_fell) begin
      next_event_status[`RCPG_EVT_PG1_LOST] = 1'b1;
    end
    if (pg_second_fell) begin
      next_event_status[`RCPG_EVT_PG2_LOST] = 1'b1;
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pg_first_prev <= `RCPG_BYTE_ZERO;
      pg_second_prev <= {`RCPG_PG2_BITS{1'b0}};
    end else begin
      pg_first_prev <= pg_first;
      pg_second_prev <= pg_second;
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      event_mask <= {`RCPG_EVT_BITS{1'b0}};
    end else if (wr_evt_mask) begin
      event_mask <= wb_dat_i[`RCPG_EVT_BITS-1:0];
    end
  end

  // Interrupt built from next status so it rises with the flag
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      event_status <= {`RCPG_EVT_BITS{1'b0}};
      irq <= 1'b0;
    end else begin
      event_status <= next_event_status;
      irq <= |(next_event_status & event_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  // Power-good reads are live, not latched; unmapped reads give zero
  always @* begin
    next_rdata = `RCPG_WORD_ZERO;
    case (reg_idx)
      `RCPG_IDX_AUX_CTRL: next_rdata[7:0] = aux_rail_control;
      `RCPG_IDX_PG_FIRST: next_rdata[7:0] = pg_first;
      `RCPG_IDX_PG_SECOND: next_rdata[5:0] = pg_second;
      `RCPG_IDX_EVT_STATUS: next_rdata[`RCPG_EVT_BITS-1:0] = event_status;
      `RCPG_IDX_EVT_MASK: next_rdata[`RCPG_EVT_BITS-1:0] = event_mask;
      default: next_rdata = `RCPG_WORD_ZERO;
    endcase
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= `RCPG_WORD_ZERO;
    end else if (rd_go) begin
      wb_dat_o <= next_rdata;
    end else begin
      wb_dat_o <= `RCPG_WORD_ZERO;
    end
  end

endmodule // rcpg_regs

/* dv/rcpg_regs_checker.sv */
/*
  Concurrent checks on the rcpg_regs ports: bus answer timing and rail outputs.
  Assumes it is bound to rcpg_regs and sees its ports only.
*/
`timescale 1ns/1ps
module rcpg_regs_checker #(
  parameter ADR_W = 10
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Rail controls
  input wire [1:0] aux_discharge_select,
  input wire [3:0] aux_voltage_code,
  input wire regulator_one_enable,
  input wire switch_b_two_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  // Taken request; adr[1:0] ignored by the slave
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire ctl_wr = take && wb_we_i && wb_sel_i[0] && wb_adr_i[ADR_W-1:2] == 8'hae;
  wire rd_pg2 = take && !wb_we_i && wb_adr_i[ADR_W-1:2] == 8'hb1;
  ////////////////////////////////////////////////////////////////////////////
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over two cycles");
  a_ack_follows_take: assert property (take |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(take))
    else $error("ack without request");
  a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data outside ack");
  a_upper_bytes_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bytes not zero");
  a_pg2_reserved_zero: assert property (rd_pg2 |=> wb_dat_o[7:6] == 2'h0)
    else $error("reserved status bits set");
  a_disch_follows_write: assert property (
    ctl_wr |-> ##2 aux_discharge_select == $past(wb_dat_i[7:6], 2))
    else $error("discharge select not updated");
  a_vcode_follows_write: assert property (
    ctl_wr |-> ##2 aux_voltage_code == $past(wb_dat_i[4:1], 2))
    else $error("voltage code not updated");
  a_one_target_on: assert property (!(regulator_one_enable && switch_b_two_enable))
    else $error("both rail targets enabled");
  ////////////////////////////////////////////////////////////////////////////
  c_ctl_write: cover property (ctl_wr);
  c_pg2_read: cover property (rd_pg2);
  c_switch_off: cover property ($fell(switch_b_two_enable));
endmodule // rcpg_regs_checker

bind rcpg_regs rcpg_regs_checker #(.ADR_W(ADR_W)) u_rcpg_regs_checker (
  .sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .aux_discharge_select(aux_discharge_select),
  .aux_voltage_code(aux_voltage_code), .regulator_one_enable(regulator_one_enable),
  .switch_b_two_enable(switch_b_two_enable));

/* dv/rcpg_regs_tb.sv */
/*
  Self-checking bench for rcpg_regs: Wishbone tasks and directed sequences.
  Assumes short shutdown counts of 20/40/60/80 cycles and a 200 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH at %0t: got %h exp %h", $time, a, b); end end
module rcpg_regs_tb;
  reg sys_clk = 0;
  reg reset_n = 0;
  reg cyc = 0;
  reg stb = 0;
  reg we = 0;
  reg [9:0] adr = 0;
  reg [3:0] sel = 4'hf;
  reg [31:0] dati = 0;
  reg [1:0] opt = 2'h1;
  reg [1:0] sdi = 0;
  reg in_seq = 0;
  reg merged = 0;
  reg esd = 0;
  reg [7:0] pg1 = 0;
  reg [5:0] pg2 = 0;
  reg [7:0] otp_rst = 8'h5a;
  reg [7:0] q;
  reg [7:0] d;
  wire [31:0] dato;
  wire ack, rego, swo, irq;
  wire [1:0] dis;
  wire [3:0] vc;
  int failures = 0;
  int compares = 0;
  int i, n, cnt;
  ////////////////////////////////////////////////////////////////////////////
  rcpg_regs #(.SD_CYC0(25'd20), .SD_CYC1(25'd40), .SD_CYC2(25'd60), .SD_CYC3(25'd80))
  u_rcpg_regs (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dati), .wb_dat_o(dato),
    .wb_ack_o(ack), .otp_ctrl_reset(otp_rst), .otp_device_option(opt),
    .otp_sd_interval(sdi), .otp_in_sequence(in_seq), .otp_switch_merged(merged),
    .pg_first_in(pg1), .pg_second_in(pg2), .emergency_shutdown(esd),
    .aux_discharge_select(dis), .aux_voltage_code(vc), .regulator_one_enable(rego),
    .switch_b_two_enable(swo), .irq(irq));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task wt(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  // Holds the request until ack is seen; data taken at that edge
  // Only the watchdog ends a wait for ack
  task automatic wb(input w, input [7:0] idx, input [7:0] dv);
    @(posedge sys_clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {idx, 2'h0};
    dati <= {24'h000000, dv};
    do begin
      @(posedge sys_clk);
    end while (ack !== 1'b1);
    q = dato[7:0];
    cyc <= 0;
    stb <= 0;
  endtask
  task rd(input [7:0] idx);
    wb(0, idx, 8'h00);
  endtask
  // Straps only load at reset release, so each option needs a reset
  task rst(input [1:0] o, input [1:0] s, input sq, input mg);
    @(posedge sys_clk);
    reset_n <= 0;
    opt <= o;
    sdi <= s;
    in_seq <= sq;
    merged <= mg;
    wt(6);
    reset_n <= 1;
    wt(6);
  endtask
  task test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    test_done;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    wt(6);
    reset_n <= 1;
    wt(6);
    rd(8'hae); `CHK(q, 8'h5a)
    rd(8'hb0); `CHK(q, 8'h00)
    rd(8'hb1); `CHK(q, 8'h00)
    $display("reset values done");
    for (i = 0; i < 16; i++) begin
      d = {i[1:0], 1'b0, i[3:0] ^ 4'h9, 1'b0};
      wb(1, 8'hae, d);
      rd(8'hae); `CHK(q, d)
      wt(1);
      `CHK(dis, i[1:0])
      `CHK(vc, i[3:0] ^ 4'h9)
    end
    sel <= 4'he;
    wb(1, 8'hae, 8'hff);
    sel <= 4'hf;
    rd(8'hae); `CHK(q, 8'hcc)
    wb(1, 8'h10, 8'hff);
    rd(8'h10); `CHK(q, 8'h00)
    wb(1, 8'hb0, 8'hff);
    rd(8'hb0); `CHK(q, 8'h00)
    $display("field access done");
    for (i = 0; i < 4; i++) begin
      // Reset value comes from the straps, so vary it per reset
      otp_rst <= 8'h96 ^ {6'h00, i[1:0]};
      rst(i[1:0], 2'h0, 1'b0, 1'b0);
      rd(8'hae); `CHK(q, 8'h96 ^ {6'h00, i[1:0]})
      `CHK(dis, 2'b10)
      wb(1, 8'hae, 8'h01);
      wt(2);
      `CHK({rego, swo}, i == 1 ? 2'b10 : i == 2 ? 2'b01 : 2'b00)
      wb(1, 8'hae, 8'h00);
      wt(2);
      `CHK({rego, swo}, 2'b00)
    end
    $display("option targets done");
    // Off time counted from the fall of swo, checked to within three cycles
    for (i = 0; i < 4; i++) begin
      rst(2'h2, i[1:0], 1'b0, 1'b0);
      wb(1, 8'hae, 8'h01);
      wt(2);
      esd <= 1;
      for (n = 0; swo !== 1'b0 && n < 20; n++) wt(1);
      for (cnt = 0; swo === 1'b0 && cnt < 200; cnt++) wt(1);
      esd <= 0;
      `CHK(cnt >= 20 * (i + 1) - 3 && cnt <= 20 * (i + 1) + 3, 1'b1)
    end
    rst(2, 3, 0, 0);
    wb(1, 8'hae, 8'h21);
    wt(2);
    esd <= 1;
    wt(30);
    `CHK(swo, 1'b1)
    esd <= 0;
    wb(1, 8'hae, 8'h20);
    wt(2);
    `CHK(swo, 1'b0)
    rst(1, 0, 1, 0);
    wb(1, 8'hae, 8'h01);
    esd <= 1;
    wt(30);
    `CHK(rego, 1'b1)
    esd <= 0;
    rst(1, 0, 1, 1);
    wb(1, 8'hae, 8'h01);
    esd <= 1;
    wt(12);
    `CHK(rego, 1'b0)
    esd <= 0;
    $display("shutdown done");
    rst(1, 0, 0, 0);
    pg1 <= 8'ha5;
    pg2 <= 6'h2b;
    wt(8);
    rd(8'hb0); `CHK(q, 8'ha5)
    rd(8'hb1); `CHK(q, 8'h2b)
    wb(1, 8'hc1, 8'h00);
    pg1 <= 8'h00;
    pg2 <= 6'h00;
    wt(8);
    `CHK(irq, 1'b0)
    rd(8'hb0); `CHK(q, 8'h00)
    rd(8'hb1); `CHK(q, 8'h00)
    rd(8'hc0); `CHK(q[3:2], 2'b11)
    wb(1, 8'hc1, 8'h04);
    wt(3);
    `CHK(irq, 1'b1)
    wb(1, 8'hc0, 8'h04);
    wt(3);
    `CHK(irq, 1'b0)
    rd(8'hc0); `CHK(q[3:2], 2'b10)
    $display("status and interrupt done");
    test_done;
  end
endmodule // rcpg_regs_tb
